// >>> src/mcu_exec_pkg.sv
package mcu_exec_pkg;
  localparam int DATA_W  = 8;
  localparam int PC_W    = 13;
  localparam int INSTR_W = 14;
  localparam int FADDR_W = 7;
  localparam int BUS_AW  = 4;
  localparam int PLH_W   = 5;
  localparam int EV_W    = 4;
  localparam int CTL_W   = 2;
  localparam int STAT_W  = 3;

  // Core clocks per instruction cycle, one per quadrature phase
  localparam int CLK_PER_CYC = 4;
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q3 = 2'h2;
  localparam logic [1:0] PH_Q4 = 2'h3;

  localparam logic [3:0] REG_W      = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_PLH    = 4'h2;
  localparam logic [3:0] REG_EVT    = 4'h3;
  localparam logic [3:0] REG_MASK   = 4'h4;
  localparam logic [3:0] REG_CTRL   = 4'h5;
  localparam logic [3:0] REG_PCL    = 4'h6;
  localparam logic [3:0] REG_PCH    = 4'h7;

  localparam int ST_C_BIT  = 0;
  localparam int ST_DC_BIT = 1;
  localparam int ST_Z_BIT  = 2;
  localparam int EV_EXT    = 0;
  localparam int EV_SKIP   = 1;
  localparam int EV_BRANCH = 2;
  localparam int EV_ILLEGAL = 3;
  localparam int CTL_RUN   = 0;
  localparam int CTL_EDGE  = 1;
  localparam int DEST_BIT  = 7;

  localparam logic [4:0] OPC_ADD_LIT = 5'h1f;
  localparam logic [5:0] OPC_AND_LIT = 6'h39;
  localparam logic [5:0] OPC_AND_F   = 6'h05;
  localparam logic [5:0] OPC_ADD_F   = 6'h07;
  localparam logic [5:0] OPC_DEC_F   = 6'h0b;
  localparam logic [2:0] OPC_BRANCH  = 3'h5;

  localparam logic [7:0]  RST_W    = 8'h00;
  localparam logic [2:0]  RST_STAT = 3'h0;
  localparam logic [4:0]  RST_PLH  = 5'h00;
  localparam logic [3:0]  RST_EVT  = 4'h0;
  localparam logic [3:0]  RST_MASK = 4'h0;
  localparam logic [1:0]  RST_CTRL = 2'h0;
  localparam logic [12:0] RST_PC   = 13'h0000;
  localparam logic [13:0] RST_IR   = 14'h0000;

  typedef enum logic [2:0] {
    ST_HALT = 3'h1,
    ST_EXEC = 3'h2,
    ST_NOP  = 3'h4
  } exec_state_t;

  typedef enum logic [1:0] {
    ALU_ADD = 2'h0,
    ALU_AND = 2'h1,
    ALU_DEC = 2'h2
  } alu_op_t;
endpackage : mcu_exec_pkg

// >>> src/alu_if.sv
`timescale 1ns/10ps
`default_nettype none
interface alu_if;
  import mcu_exec_pkg::*;
  logic [7:0] a;
  logic [7:0] b;
  alu_op_t    op;
  logic [7:0] res;
  logic       c;
  logic       dc;
  logic       z;
  modport core (output a, b, op, input res, c, dc, z);
  modport alu  (input a, b, op, output res, c, dc, z);
endinterface : alu_if
`default_nettype wire

// >>> src/exec_alu.sv
`timescale 1ns/10ps
`default_nettype none
module exec_alu (
  alu_if.alu bus
);
  import mcu_exec_pkg::*;

  logic [8:0] sum9;
  logic [4:0] sum5;

  assign sum9 = {1'b0, bus.a} + {1'b0, bus.b};
  assign sum5 = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]};

  always_comb begin
    bus.res = 8'h00;
    bus.c   = 1'b0;
    bus.dc  = 1'b0;
    case (bus.op)
      ALU_ADD: begin
        bus.res = sum9[7:0];
        bus.c   = sum9[8];
        bus.dc  = sum5[4];
      end
      ALU_AND: begin
        bus.res = bus.a & bus.b;
      end
      ALU_DEC: begin
        bus.res = bus.a - 8'h01;
      end
      default: begin
        bus.res = 8'h00;
      end
    endcase
    bus.z = (bus.res == 8'h00);
  end
endmodule : exec_alu
`default_nettype wire

// >>> src/mcu_exec_core.sv
// Contract
// - Add literal to W, flags C DC Z
// - AND literal into W, Z only
// - AND W with file to destination, Z
// - Destination bit zero W, one file
// - Add W and file to destination
// - Decrement file, flags untouched
// - Zero decrement result discards prefetch, runs NOP
// - Branch loads PC, upper from latch
// - Edge flag set only in Q4 or Q1
`timescale 1ns/10ps
`default_nettype none
module mcu_exec_core (
  input  wire logic                  i_clk,
  input  wire logic                  i_nrst,
  input  wire logic [3:0]            i_addr,
  input  wire logic [7:0]            i_wdata,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  output logic      [7:0]            o_rdata,
  output logic                       o_irq,
  input  wire logic [13:0]           i_instr,
  output logic      [12:0]           o_pc,
  input  wire logic [7:0]            i_file_rdata,
  output logic      [6:0]            o_file_addr,
  output logic      [7:0]            o_file_wdata,
  output logic                       o_file_we,
  input  wire logic                  i_int_pin
);
  import mcu_exec_pkg::*;

  alu_if alu_bus ();

  exec_alu u_alu (
    .bus (alu_bus.alu)
  );

  logic [1:0]   phase_ff,  nxt_phase;
  exec_state_t  st_ff,     nxt_st;
  logic [13:0]  ir_ff,     nxt_ir;
  logic [12:0]  pc_ff,     nxt_pc;
  logic [7:0]   w_ff,      nxt_w;
  logic [2:0]   stat_ff,   nxt_stat;
  logic [7:0]   opnd_ff,   nxt_opnd;
  logic         skip_ff,   nxt_skip;
  logic [6:0]   faddr_ff,  nxt_faddr;
  logic [7:0]   fwd_ff,    nxt_fwd;
  logic         fwe_ff,    nxt_fwe;
  logic [4:0]   plh_ff,    nxt_plh;
  logic [3:0]   evt_ff,    nxt_evt;
  logic [3:0]   mask_ff,   nxt_mask;
  logic [1:0]   ctrl_ff,   nxt_ctrl;
  logic [7:0]   rdata_ff,  nxt_rdata;
  logic         irq_ff,    nxt_irq;
  logic         pin_s1_ff;
  logic         pin_s2_ff;
  logic         pin_s3_ff;
  logic         pend_ff,   nxt_pend;

  logic         is_addl;
  logic         is_andl;
  logic         is_andf;
  logic         is_addf;
  logic         is_dec;
  logic         is_br;
  logic         is_file;
  logic         exec_q3;
  logic         exec_q4;
  logic         edge_seen;
  logic         ext_set;
  logic [3:0]   set_vec;
  logic [3:0]   clr_vec;
  logic [12:0]  br_target;

  assign is_addl = (ir_ff[13:9] == OPC_ADD_LIT);
  assign is_andl = (ir_ff[13:8] == OPC_AND_LIT);
  assign is_andf = (ir_ff[13:8] == OPC_AND_F);
  assign is_addf = (ir_ff[13:8] == OPC_ADD_F);
  assign is_dec  = (ir_ff[13:8] == OPC_DEC_F);
  assign is_br   = (ir_ff[13:11] == OPC_BRANCH);
  assign is_file = is_andf | is_addf | is_dec;
  assign exec_q3 = (st_ff == ST_EXEC) && (phase_ff == PH_Q3);
  assign exec_q4 = (st_ff == ST_EXEC) && (phase_ff == PH_Q4);
  assign br_target = {plh_ff[4:3], ir_ff[10:0]};

  // Operand steering into the shared ALU
  always_comb begin
    alu_bus.a  = w_ff;
    alu_bus.b  = opnd_ff;
    alu_bus.op = ALU_ADD;
    if (is_addl | is_andl) begin
      alu_bus.b = ir_ff[7:0];
    end
    if (is_andl | is_andf) begin
      alu_bus.op = ALU_AND;
    end
    if (is_dec) begin
      alu_bus.a  = opnd_ff;
      alu_bus.op = ALU_DEC;
    end
  end

  // Execution pipeline: Q2 read file, Q3 write back, Q4 fetch
  always_comb begin
    nxt_phase = phase_ff + 2'h1;
    nxt_st    = st_ff;
    nxt_ir    = ir_ff;
    nxt_pc    = pc_ff;
    nxt_w     = w_ff;
    nxt_stat  = stat_ff;
    nxt_opnd  = opnd_ff;
    nxt_skip  = skip_ff;
    nxt_faddr = ir_ff[6:0];
    nxt_fwd   = fwd_ff;
    nxt_fwe   = 1'b0;
    if (i_wr && (i_addr == REG_W)) begin
      nxt_w = i_wdata;
    end
    if (i_wr && (i_addr == REG_STATUS)) begin
      nxt_stat = i_wdata[2:0];
    end
    case (phase_ff)
      PH_Q2: begin
        if (st_ff == ST_EXEC) begin
          nxt_opnd = i_file_rdata;
        end
      end
      PH_Q3: begin
        nxt_skip = 1'b0;
        if (st_ff == ST_EXEC) begin
          if (is_addl | is_andl) begin
            nxt_w = alu_bus.res;
          end
          if (is_file) begin
            if (ir_ff[DEST_BIT]) begin
              nxt_fwe = 1'b1;
              nxt_fwd = alu_bus.res;
            end else begin
              nxt_w = alu_bus.res;
            end
          end
          if (is_addl | is_addf) begin
            nxt_stat[ST_C_BIT]  = alu_bus.c;
            nxt_stat[ST_DC_BIT] = alu_bus.dc;
          end
          if (is_addl | is_addf | is_andl | is_andf) begin
            nxt_stat[ST_Z_BIT] = alu_bus.z;
          end
          nxt_skip = is_dec & alu_bus.z;
        end
      end
      PH_Q4: begin
        case (st_ff)
          ST_HALT: begin
            if (ctrl_ff[CTL_RUN]) begin
              // Fill cycle only: the held pc is fetched at the
              // end of the NOP cycle, so no word is lost
              nxt_st = ST_NOP;
            end
          end
          ST_EXEC, ST_NOP: begin
            nxt_ir = i_instr;
            nxt_pc = pc_ff + 13'h0001;
            if (!ctrl_ff[CTL_RUN]) begin
              nxt_pc = pc_ff;
              nxt_st = ST_HALT;
            end else if ((st_ff == ST_EXEC) && is_br) begin
              nxt_pc = br_target;
              nxt_st = ST_NOP;
            end else if ((st_ff == ST_EXEC) && skip_ff) begin
              nxt_st = ST_NOP;
            end else begin
              nxt_st = ST_EXEC;
            end
          end
          default: begin
            nxt_st = ST_HALT;
          end
        endcase
      end
      default: begin
        nxt_skip = skip_ff;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      phase_ff <= PH_Q1;
      st_ff    <= ST_HALT;
      ir_ff    <= RST_IR;
      pc_ff    <= RST_PC;
      w_ff     <= RST_W;
      stat_ff  <= RST_STAT;
      opnd_ff  <= 8'h00;
      skip_ff  <= 1'b0;
      faddr_ff <= 7'h00;
      fwd_ff   <= 8'h00;
      fwe_ff   <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
      st_ff    <= nxt_st;
      ir_ff    <= nxt_ir;
      pc_ff    <= nxt_pc;
      w_ff     <= nxt_w;
      stat_ff  <= nxt_stat;
      opnd_ff  <= nxt_opnd;
      skip_ff  <= nxt_skip;
      faddr_ff <= nxt_faddr;
      fwd_ff   <= nxt_fwd;
      fwe_ff   <= nxt_fwe;
    end
  end

  // Pin synchroniser and edge capture
  assign edge_seen = ctrl_ff[CTL_EDGE] ? (pin_s2_ff & ~pin_s3_ff)
                                       : (~pin_s2_ff & pin_s3_ff);
  assign ext_set = pend_ff &&
                   ((phase_ff == PH_Q4) || (phase_ff == PH_Q1));
  assign set_vec = {exec_q4 & ~(is_addl | is_andl | is_file | is_br),
                    exec_q4 & is_br,
                    exec_q4 & skip_ff,
                    ext_set};
  assign clr_vec = (i_wr && (i_addr == REG_EVT)) ? i_wdata[3:0] : 4'h0;

  always_comb begin
    nxt_plh   = plh_ff;
    nxt_mask  = mask_ff;
    nxt_ctrl  = ctrl_ff;
    nxt_rdata = 8'h00;
    nxt_pend  = edge_seen | (pend_ff & ~ext_set);
    nxt_evt   = (evt_ff & ~clr_vec) | set_vec;
    if (i_wr) begin
      case (i_addr)
        REG_PLH:  nxt_plh  = i_wdata[4:0];
        REG_MASK: nxt_mask = i_wdata[3:0];
        REG_CTRL: nxt_ctrl = i_wdata[1:0];
        default:  nxt_plh  = plh_ff;
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        REG_W:      nxt_rdata = w_ff;
        REG_STATUS: nxt_rdata = {5'h00, stat_ff};
        REG_PLH:    nxt_rdata = {3'h0, plh_ff};
        REG_EVT:    nxt_rdata = {4'h0, evt_ff};
        REG_MASK:   nxt_rdata = {4'h0, mask_ff};
        REG_CTRL:   nxt_rdata = {6'h00, ctrl_ff};
        REG_PCL:    nxt_rdata = pc_ff[7:0];
        REG_PCH:    nxt_rdata = {3'h0, pc_ff[12:8]};
        default:    nxt_rdata = 8'h00;
      endcase
    end
    nxt_irq = |(nxt_evt & nxt_mask);
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      plh_ff    <= RST_PLH;
      evt_ff    <= RST_EVT;
      mask_ff   <= RST_MASK;
      ctrl_ff   <= RST_CTRL;
      rdata_ff  <= 8'h00;
      irq_ff    <= 1'b0;
      pin_s1_ff <= 1'b0;
      pin_s2_ff <= 1'b0;
      pin_s3_ff <= 1'b0;
      pend_ff   <= 1'b0;
    end else begin
      plh_ff    <= nxt_plh;
      evt_ff    <= nxt_evt;
      mask_ff   <= nxt_mask;
      ctrl_ff   <= nxt_ctrl;
      rdata_ff  <= nxt_rdata;
      irq_ff    <= nxt_irq;
      pin_s1_ff <= i_int_pin;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      pend_ff   <= nxt_pend;
    end
  end

  assign o_rdata      = rdata_ff;
  assign o_irq        = irq_ff;
  assign o_pc         = pc_ff;
  assign o_file_addr  = faddr_ff;
  assign o_file_wdata = fwd_ff;
  assign o_file_we    = fwe_ff;

  localparam int SKIP_MIN = 1;
  localparam int SKIP_MAX = 3;

  logic [8:0] chk_sum9;
  logic [4:0] chk_sum5;
  assign chk_sum9 = {1'b0, w_ff} + {1'b0, opnd_ff};
  assign chk_sum5 = {1'b0, w_ff[3:0]} + {1'b0, opnd_ff[3:0]};

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  sequence s_dec_zero;
    exec_q3 && is_dec && (opnd_ff == 8'h01);
  endsequence

  sequence s_branch;
    exec_q4 && is_br && ctrl_ff[CTL_RUN];
  endsequence

  a_add_lit_w: assert property (
    exec_q3 && is_addl |=>
      (w_ff == $past(w_ff) + $past(ir_ff[7:0])) &&
      (stat_ff[ST_Z_BIT] == (w_ff == 8'h00)))
    else $error("add literal result wrong");

  a_and_lit_w: assert property (
    exec_q3 && is_andl && !i_wr |=>
      (w_ff == ($past(w_ff) & $past(ir_ff[7:0]))) &&
      $stable(stat_ff[1:0]))
    else $error("and literal result or flags wrong");

  a_and_file_dst: assert property (
    exec_q3 && is_andf && ir_ff[DEST_BIT] |=>
      o_file_we && (o_file_wdata == ($past(w_ff) & $past(opnd_ff))))
    else $error("and file write back wrong");

  a_dest_w_only: assert property (
    exec_q3 && is_file && !ir_ff[DEST_BIT] |=>
      !o_file_we ##1 !o_file_we)
    else $error("file written with destination W");

  a_add_file_cy: assert property (
    exec_q3 && is_addf && !i_wr |=>
      (stat_ff[ST_C_BIT] == $past(chk_sum9[8])) &&
      (stat_ff[ST_DC_BIT] == $past(chk_sum5[4])))
    else $error("add file carry flags wrong");

  a_dec_no_flags: assert property (
    exec_q3 && is_dec && !i_wr |=> $stable(stat_ff) ##1 $stable(stat_ff))
    else $error("decrement changed status");

  a_skip_to_nop: assert property (
    s_dec_zero |-> ##[SKIP_MIN:SKIP_MAX] (st_ff != ST_EXEC))
    else $error("zero decrement did not discard prefetch");

  a_branch_pc: assert property (
    s_branch |=> (pc_ff == $past(br_target)) && (st_ff == ST_NOP))
    else $error("branch target or dead cycle wrong");

  a_flag_phase: assert property (
    $rose(evt_ff[EV_EXT]) |->
      (($past(phase_ff) == PH_Q4) || ($past(phase_ff) == PH_Q1)))
    else $error("edge flag set outside Q4 Q1");

  a_irq_level: assert property (
    ##1 (o_irq == |(evt_ff & mask_ff)))
    else $error("interrupt level disagrees with status");
endmodule : mcu_exec_core
`default_nettype wire

// >>> sim/prog_file_model.sv
`timescale 1ns/10ps
`default_nettype none
module prog_file_model (
  input  wire logic        i_clk,
  input  wire logic [12:0] i_pc,
  output logic      [13:0] o_instr,
  input  wire logic [6:0]  i_faddr,
  input  wire logic [7:0]  i_fwdata,
  input  wire logic        i_fwe,
  output logic      [7:0]  o_frdata
);
  logic [13:0] rom [8192];
  logic [7:0]  rf  [128];

  initial begin
    foreach (rom[i]) rom[i] = 14'h0000;
    foreach (rf[i]) rf[i] = 8'(i);
  end

  assign o_instr  = rom[i_pc];
  assign o_frdata = rf[i_faddr];

  always @(posedge i_clk) begin
    if (i_fwe) begin
      rf[i_faddr] <= i_fwdata;
    end
  end
endmodule : prog_file_model
`default_nettype wire

// >>> sim/mcu_instruction_subset_exec_test.sv
`timescale 1ns/10ps
`default_nettype none
module mcu_instruction_subset_exec_test;
  import mcu_exec_pkg::*;
  logic        i_clk, i_nrst, i_wr, i_rd, i_int_pin, o_irq, o_file_we;
  logic        rd_dly, d;
  logic [3:0]  i_addr;
  logic [7:0]  i_wdata, o_rdata, i_file_rdata, o_file_wdata, w, k, f;
  logic [13:0] i_instr;
  logic [12:0] o_pc, t;
  logic [6:0]  o_file_addr, a;
  logic [4:0]  plh;
  logic [2:0]  s;
  logic [10:0] r, k11;
  int          err_total, total_checks;
  integer      seed;
  logic [7:0]  rd_q[$];
  logic [14:0] fw_q[$];

  mcu_exec_core dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_irq(o_irq), .i_instr(i_instr), .o_pc(o_pc),
    .i_file_rdata(i_file_rdata), .o_file_addr(o_file_addr),
    .o_file_wdata(o_file_wdata), .o_file_we(o_file_we),
    .i_int_pin(i_int_pin));
  prog_file_model mem (.i_clk(i_clk), .i_pc(o_pc), .o_instr(i_instr),
    .i_faddr(o_file_addr), .i_fwdata(o_file_wdata), .i_fwe(o_file_we),
    .o_frdata(i_file_rdata));

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  task automatic check(string nm, logic [14:0] seen, logic [14:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  // Results are matched in order against the notes left by the drivers
  always @(posedge i_clk) begin
    rd_dly <= i_rd;
    if (rd_dly) begin
      check("rdata", o_rdata, rd_q.size() ? 15'(rd_q.pop_front()) : 15'h7fff);
    end
    if (o_file_we) begin
      check("fwrite", {o_file_addr, o_file_wdata},
            fw_q.size() ? fw_q.pop_front() : 15'h7fff);
    end
  end

  task automatic wr(logic [3:0] ad, logic [7:0] dt);
    @(posedge i_clk);
    i_addr  <= ad;
    i_wdata <= dt;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(logic [3:0] ad, logic [7:0] e);
    @(posedge i_clk);
    i_addr <= ad;
    i_rd   <= 1'b1;
    rd_q.push_back(e);
    @(posedge i_clk);
    i_rd <= 1'b0;
  endtask : rd

  task automatic note(string nm);
    repeat (3) @(posedge i_clk);
    check("pending", 15'(rd_q.size() + fw_q.size()), 15'h0000);
    $display("test %s done", nm);
  endtask : note

  task automatic restart();
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
  endtask : restart

  function automatic logic [13:0] br(logic [10:0] kk);
    return {OPC_BRANCH, kk};
  endfunction : br

  function automatic logic [10:0] add8(logic [7:0] x, logic [7:0] y);
    logic [8:0] sm;
    logic [4:0] h;
    sm = x + y;
    h  = x[3:0] + y[3:0];
    return {sm[7:0] == 8'h00, h[4], sm[8], sm[7:0]};
  endfunction : add8

  task automatic one(logic [13:0] p0, logic [13:0] p1, logic [7:0] w0,
                     logic [2:0] s0, logic [4:0] ph, logic [7:0] ew,
                     logic [2:0] es, logic [3:0] ev);
    mem.rom[0] = p0;
    mem.rom[1] = p1;
    mem.rom[2] = br(11'h002);
    restart();
    wr(REG_W, w0);
    wr(REG_STATUS, {5'h00, s0});
    wr(REG_PLH, {3'h0, ph});
    wr(REG_CTRL, 8'h01);
    repeat (80) @(posedge i_clk);
    wr(REG_CTRL, 8'h00);
    repeat (8) @(posedge i_clk);
    rd(REG_W, ew);
    rd(REG_STATUS, {5'h00, es});
    rd(REG_EVT, {4'h0, ev});
    note("program");
  endtask : one

  initial begin
    seed      = 32'hc7e9_1d8c;
    i_nrst    = 1'b0;
    i_wr      = 1'b0;
    i_rd      = 1'b0;
    rd_dly    = 1'b0;
    i_addr    = 4'h0;
    i_wdata   = 8'h00;
    i_int_pin = 1'b0;
    repeat (20) @(posedge i_clk);
    i_nrst <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      rd(4'(i), 8'h00);
    end
    note("reset");
    for (int i = 0; i < 3; i++) begin
      w = (i == 0) ? 8'($random(seed)) : (i == 1) ? 8'h08 : 8'hff;
      k = (i == 0) ? 8'($random(seed)) : (i == 1) ? 8'h08 : 8'h01;
      r = add8(w, k);
      one({OPC_ADD_LIT, 1'b0, k}, br(11'h001), w, 3'h0, 5'h00, r[7:0],
          r[10:8], 4'h4);
    end
    for (int i = 0; i < 2; i++) begin
      w = 8'($random(seed));
      k = i ? 8'h00 : 8'($random(seed));
      one({OPC_AND_LIT, k}, br(11'h001), w, 3'h3, 5'h00, w & k,
          {(w & k) == 8'h00, 2'b11}, 4'h4);
    end
    for (int i = 0; i < 4; i++) begin
      a = 7'($random(seed));
      f = (i == 3) ? 8'h80 : 8'($random(seed));
      w = (i == 3) ? 8'h80 : 8'($random(seed));
      d = i[0];
      mem.rf[a] = f;
      r = (i < 2) ? {(w & f) == 8'h00, 2'b11, w & f} : add8(w, f);
      if (d) fw_q.push_back({a, r[7:0]});
      one({(i < 2) ? OPC_AND_F : OPC_ADD_F, d, a}, br(11'h001), w, 3'h3,
          5'h00, d ? w : r[7:0], r[10:8], 4'h4);
    end
    for (int i = 0; i < 2; i++) begin
      a = 7'($random(seed));
      w = 8'($random(seed));
      s = 3'($random(seed));
      mem.rf[a] = i ? 8'h00 : 8'h01;
      if (i == 0) fw_q.push_back({a, 8'h00});
      one({OPC_DEC_F, ~i[0], a}, {OPC_ADD_LIT, 1'b0, 8'h01}, w, s, 5'h00,
          i ? 8'h00 : w, i ? 3'h7 : s, i ? 4'h4 : 4'h6);
    end
    one(14'h0000, br(11'h001), w, s, 5'h00, w, s, 4'hc);
    k11 = {1'b1, 2'($random(seed)), 1'b0, 6'($random(seed)), 1'b0};
    plh = 5'($random(seed));
    t   = {plh[4:3], k11};
    w   = 8'($random(seed));
    r   = add8(w, 8'h0f);
    mem.rom[t] = {OPC_ADD_LIT, 1'b0, 8'h0f};
    mem.rom[t + 13'h0001] = br(11'(t + 13'h0001));
    one(br(k11), {OPC_ADD_LIT, 1'b0, 8'h55}, w, 3'h0, plh, r[7:0], r[10:8],
        4'h4);
    rd(REG_PCH, {3'h0, t[12:8]});
    note("branch");
    restart();
    wr(REG_CTRL, 8'h02);
    wr(REG_MASK, 8'h01);
    i_int_pin <= 1'b1;
    repeat (12) @(negedge i_clk);
    check("irq", o_irq, 15'h0001);
    rd(REG_EVT, 8'h01);
    wr(REG_MASK, 8'h00);
    @(negedge i_clk);
    check("irq", o_irq, 15'h0000);
    wr(REG_EVT, 8'h01);
    rd(REG_EVT, 8'h00);
    wr(REG_CTRL, 8'h00);
    wr(REG_MASK, 8'h01);
    i_int_pin <= 1'b0;
    repeat (12) @(negedge i_clk);
    check("irq", o_irq, 15'h0001);
    note("interrupt");
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    err_total++;
    wrap_up();
  end
endmodule : mcu_instruction_subset_exec_test
`default_nettype wire
